// ---- design/ams_seq.sv ----
// i2c master acknowledge and stop sequencer with apb registers
// assumes open-drain scl/sda resolved outside; pins are asynchronous
// Summary of operation
// - ack start bit set: pull scl low, put ack value on sda
// - after one rollover period release scl
// - once scl seen high, count one period, then pull scl low
// - ack end: clear start bit, stop generator, go idle
// - buffer write during ack sets collision flag, buffer unchanged
// - scl held low after ninth falling edge at transfer end
// - stop start: pull sda low; when seen low reload and count
// - on timeout release scl, one period later release sda
// - stop detected set when sda high while scl high
// - one period after stop detect clear start bit, set irq flag
// - buffer write during stop sets collision flag, write ignored
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module ams_seq (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// i2c pins
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// interrupt flag level
	output logic portIrqFlag
);
	import ams_pkg::*;

	// ====================================
	// pin synchronisers
	// reset to the pulled-up idle level, so no false low follows reset
	logic sclMeta_q, sclSync_q, sdaMeta_q, sdaSync_q;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sclMeta_q <= 1'b1;
			sclSync_q <= 1'b1;
			sdaMeta_q <= 1'b1;
			sdaSync_q <= 1'b1;
		end else begin
			sclMeta_q <= sclIn;
			sclSync_q <= sclMeta_q;
			sdaMeta_q <= sdaIn;
			sdaSync_q <= sdaMeta_q;
		end
	end

	// ====================================
	// apb decode
	logic wrEn, rdEn, mapped;
	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && !penable && !pwrite;
	assign mapped = (paddr == CTRL_OFS) || (paddr == STAT_OFS) || (paddr == BRG_OFS) || (paddr == BUF_OFS);
	// no wait states: read data is captured in setup and stands through access
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ====================================
	// registers and sequencer
	ams_state_t state_q, state_d;
	logic ackStart_q, ackStart_d, ackValue_q, ackValue_d;
	logic stopStart_q, stopStart_d, holdScl_q, holdScl_d;
	logic stopDet_q, stopDet_d, write_collision_flag_q, write_collision_flag_d, irq_q, irq_d;
	logic [7:0] brg_q, brg_d, buf_q, buf_d;
	logic sclLow_q, sclLow_d, sdaLow_q, sdaLow_d;
	logic [31:0] prdata_q, prdata_d;
	logic brgRun, brgLoad, tick, seqBusy;
	logic brgRun_q, brgRun_d;

	// a start bit not yet taken up by the sequencer counts as busy too,
	// so a buffer write in that very cycle still collides
	assign seqBusy = (state_q != AMS_IDLE) || ackStart_q || stopStart_q;

	// ====================================
	// generator run history
	// first cycle of the stop countdown needs a reload, remembered here
	always_comb begin
		brgRun_d = brgRun;
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			brgRun_q <= 1'b0;
		end else begin
			brgRun_q <= brgRun_d;
		end
	end

	// period shared by both sequences
	ams_brg brgInst (
		.ref_clk(ref_clk),
		.srst(srst),
		.run(brgRun),
		.load(brgLoad),
		.reload(brg_q),
		.tick(tick)
	);

	// ====================================
	// next values of the sequencer and registers
	always_comb begin
		state_d = state_q;
		ackStart_d = ackStart_q;
		ackValue_d = ackValue_q;
		stopStart_d = stopStart_q;
		holdScl_d = holdScl_q;
		stopDet_d = stopDet_q;
		write_collision_flag_d = write_collision_flag_q;
		irq_d = irq_q;
		brg_d = brg_q;
		buf_d = buf_q;
		sclLow_d = sclLow_q;
		sdaLow_d = sdaLow_q;
		brgRun = 1'b0;
		brgLoad = 1'b0;
		prdata_d = prdata_q;

		// software writes; a set from hardware below wins over a clear here
		if (wrEn) begin
			unique case (paddr)
				CTRL_OFS: begin
					if (!seqBusy) begin
						ackValue_d = pwdata[ACK_VALUE_BIT];
						ackStart_d = pwdata[ACK_START_BIT];
						stopStart_d = pwdata[STOP_START_BIT] && !pwdata[ACK_START_BIT];
					end
					holdScl_d = pwdata[HOLD_SCL_BIT];
				end
				STAT_OFS: begin
					// write one to clear
					if (pwdata[STOP_DET_BIT]) stopDet_d = 1'b0;
					if (pwdata[WRITE_COLLISION_FLAG_BIT]) write_collision_flag_d = 1'b0;
					if (pwdata[IRQ_BIT]) irq_d = 1'b0;
				end
				BRG_OFS: begin
					brg_d = pwdata[7:0];
				end
				BUF_OFS: begin
					if (seqBusy) begin
						write_collision_flag_d = 1'b1;
					end else begin
						buf_d = pwdata[7:0];
					end
				end
				default: begin
				end
			endcase
		end

		unique case (state_q)
			AMS_IDLE: begin
				// idle keeps scl low after the ninth clock while held
				sclLow_d = holdScl_q;
				sdaLow_d = 1'b0;
				if (ackStart_q) begin
					sclLow_d = 1'b1;
					sdaLow_d = !ackValue_q;
					brgLoad = 1'b1;
					brgRun = 1'b1;
					state_d = AMS_ACK_LOW;
				end else if (stopStart_q) begin
					sclLow_d = 1'b1;
					sdaLow_d = 1'b1;
					state_d = AMS_STOP_SDALOW;
				end
			end
			AMS_ACK_LOW: begin
				brgRun = 1'b1;
				if (tick) begin
					sclLow_d = 1'b0;
					state_d = AMS_ACK_WAITHI;
				end
			end
			AMS_ACK_WAITHI: begin
				// a slave stretching scl holds us here
				if (sclSync_q) begin
					brgLoad = 1'b1;
					brgRun = 1'b1;
					state_d = AMS_ACK_HIGH;
				end
			end
			AMS_ACK_HIGH: begin
				brgRun = 1'b1;
				if (tick) begin
					sclLow_d = 1'b1;
					sdaLow_d = 1'b0;
					ackStart_d = 1'b0;
					state_d = AMS_IDLE;
				end
			end
			AMS_STOP_SDALOW: begin
				// nothing counts until the line is seen low; a stuck bus waits here
				if (!sdaSync_q) begin
					brgRun = 1'b1;
					brgLoad = !brgRun_q;
					if (tick) begin
						sclLow_d = 1'b0;
						state_d = AMS_STOP_SCLHI;
					end
				end
			end
			AMS_STOP_SCLHI: begin
				brgRun = 1'b1;
				if (tick) begin
					sdaLow_d = 1'b0;
					state_d = AMS_STOP_SDAHI;
				end
			end
			AMS_STOP_SDAHI: begin
				// a slave may still stretch scl; detection waits for both lines
				if (sdaSync_q && sclSync_q) begin
					stopDet_d = 1'b1;
					brgLoad = 1'b1;
					brgRun = 1'b1;
					state_d = AMS_STOP_DONE;
				end
			end
			AMS_STOP_DONE: begin
				// flag follows the status by one period, so software sees both
				brgRun = 1'b1;
				if (tick) begin
					stopStart_d = 1'b0;
					irq_d = 1'b1;
					state_d = AMS_IDLE;
				end
			end
		endcase

		if (rdEn) begin
			prdata_d = 32'h0000_0000;
			unique case (paddr)
				CTRL_OFS: begin
					prdata_d[ACK_START_BIT] = ackStart_q;
					prdata_d[ACK_VALUE_BIT] = ackValue_q;
					prdata_d[STOP_START_BIT] = stopStart_q;
					prdata_d[HOLD_SCL_BIT] = holdScl_q;
				end
				STAT_OFS: begin
					prdata_d[STOP_DET_BIT] = stopDet_q;
					prdata_d[WRITE_COLLISION_FLAG_BIT] = write_collision_flag_q;
					prdata_d[IRQ_BIT] = irq_q;
					prdata_d[BUSY_BIT] = seqBusy;
				end
				BRG_OFS: prdata_d[7:0] = brg_q;
				BUF_OFS: prdata_d[7:0] = buf_q;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q <= AMS_IDLE;
			ackStart_q <= 1'b0;
			ackValue_q <= 1'b0;
			stopStart_q <= 1'b0;
			holdScl_q <= 1'b0;
			stopDet_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			irq_q <= 1'b0;
			brg_q <= BRG_RESET;
			buf_q <= BUF_RESET;
			sclLow_q <= 1'b0;
			sdaLow_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			ackStart_q <= ackStart_d;
			ackValue_q <= ackValue_d;
			stopStart_q <= stopStart_d;
			holdScl_q <= holdScl_d;
			stopDet_q <= stopDet_d;
			write_collision_flag_q <= write_collision_flag_d;
			irq_q <= irq_d;
			brg_q <= brg_d;
			buf_q <= buf_d;
			sclLow_q <= sclLow_d;
			sdaLow_q <= sdaLow_d;
			prdata_q <= prdata_d;
		end
	end

	// ====================================
	// outputs: open drain, only ever drive low
	// a high level only ever comes from the bus pull-ups
	assign sclOut = 1'b0;
	assign sclOe = sclLow_q;
	assign sdaOut = 1'b0;
	assign sdaOe = sdaLow_q;
	assign prdata = prdata_q;
	assign portIrqFlag = irq_q;
endmodule

// ---- design/ams_pkg.sv ----
// constants for the i2c acknowledge / stop sequencer
// assumes a single 10 MHz clock and an apb register bus
package ams_pkg;
	// ====================================
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] BRG_OFS = 8'h08;
	localparam logic [7:0] BUF_OFS = 8'h0c;
	// ====================================
	// control fields
	localparam int ACK_START_BIT = 0;
	localparam int ACK_VALUE_BIT = 1;
	localparam int STOP_START_BIT = 2;
	localparam int HOLD_SCL_BIT = 3;
	// status fields
	localparam int STOP_DET_BIT = 0;
	localparam int WRITE_COLLISION_FLAG_BIT = 1;
	localparam int IRQ_BIT = 2;
	localparam int BUSY_BIT = 3;
	// ====================================
	// reset values
	localparam logic [7:0] BRG_RESET = 8'h09;
	localparam logic [7:0] BUF_RESET = 8'h00;
	typedef enum logic [2:0] {
		AMS_IDLE,
		AMS_ACK_LOW,
		AMS_ACK_WAITHI,
		AMS_ACK_HIGH,
		AMS_STOP_SDALOW,
		AMS_STOP_SCLHI,
		AMS_STOP_SDAHI,
		AMS_STOP_DONE
	} ams_state_t;
endpackage

// ---- design/ams_brg.sv ----
// baud rate generator: reloadable down counter
// assumes the sequencer gives a load pulse and a run level
`timescale 1ns/1ps
module ams_brg (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// control
	input wire logic run,
	input wire logic load,
	input wire logic [7:0] reload,
	// rollover pulse
	output logic tick
);
	import ams_pkg::*;
	logic [7:0] cnt_q, cnt_d;
	always_comb begin
		cnt_d = cnt_q;
		if (load || !run) begin
			cnt_d = reload;
		end else if (cnt_q == 8'h00) begin
			cnt_d = reload;
		end else begin
			cnt_d = cnt_q - 8'h01;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_q <= BRG_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// one period is reload+1 cycles
	assign tick = run && !load && (cnt_q == 8'h00);
endmodule

// ---- testbench/ams_seq_monitor.sv ----
// checker on the sequencer ports
// assumes pins resolved by a stand-in with pull-ups
`timescale 1ns/1ps
module ams_seq_monitor import ams_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins and flag
	input wire logic sclIn,
	input wire logic sclOe,
	input wire logic sdaIn,
	input wire logic sdaOe,
	input wire logic portIrqFlag
);
	// ==========
	// helpers
	logic wr, ackV_q;
	assign wr = psel && penable && pwrite;
	always_ff @(posedge ref_clk) if (wr && paddr == CTRL_OFS) ackV_q <= pwdata[ACK_VALUE_BIT];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// scl let go while sda still pulled low
	sequence relScl; $fell(sclOe) && sdaOe; endsequence
	a_ready_high: assert property (psel && penable |-> pready) else $error("pready low");
	a_bad_addr: assert property (psel && penable && paddr > BUF_OFS |-> pslverr) else $error("no slave error");
	a_ack_present: assert property (wr && paddr == CTRL_OFS && pwdata[ACK_START_BIT] && !sclOe && !sdaOe
		|-> ##[1:2] (sclOe && sdaOe != ackV_q)) else $error("ack bit not presented");
	a_sda_hold: assert property (relScl |=> sdaOe) else $error("sda let go with scl");
	a_rel_bound: assert property (relScl |-> ##[1:600] (sclOe || !sdaOe)) else $error("stuck");
	a_scl_wait: assert property (!sclOe && !sclIn && !psel && !$past(psel) |=> !sclOe)
		else $error("scl pulled while stretched");
	a_irq_kept: assert property ($fell(portIrqFlag) |-> $past(wr && paddr == STAT_OFS))
		else $error("irq cleared by itself");
	a_irq_after: assert property ($rose(portIrqFlag) |-> $past(sclIn && sdaIn, 3) && !sclOe && !sdaOe)
		else $error("irq before stop");
endmodule

// ---- testbench/ams_slave_model.sv ----
// slave stand-in: pull-ups on both lines, clock stretch
// assumes an enable high means the master pulls low
`timescale 1ns/1ps
module ams_slave_model (
	// clock
	input wire logic ref_clk,
	// master pulls from the design
	input wire logic sclOe,
	input wire logic sdaOe,
	// stretch length from the bench
	input wire logic [3:0] stretch,
	// resolved bus levels
	output logic sclIn,
	output logic sdaIn
);
	// ==========
	// stretch scl after each release
	int hold = 0;
	logic last = 1'b0;
	always @(posedge ref_clk) begin
		if (last && !sclOe) hold <= stretch;
		else if (hold > 0) hold <= hold - 1;
		last <= sclOe;
	end
	assign sclIn = !(sclOe || hold > 0 || (last && stretch > 0));
	assign sdaIn = !sdaOe;
endmodule

// ---- testbench/tb_top.sv ----
// bench: apb master, slave stand-in, register scoreboard
// assumes ams_seq and ams_pkg from the design folder
`timescale 1ns/1ps
module tb_top;
	import ams_pkg::*;
	logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe, portIrqFlag;
	logic [3:0] stretch = 0;
	int fail_count = 0, checks = 0, cyc = 0, gap = 0, seed = 32'hdf88, rel, expBuf, v;
	int bufModel[$];
	ams_seq ams_seq_i (
		.ref_clk(ref_clk),
		.srst(srst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.sclIn(sclIn),
		.sclOut(sclOut),
		.sclOe(sclOe),
		.sdaIn(sdaIn),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.portIrqFlag(portIrqFlag)
	);
	ams_slave_model ams_slave_model_i (.ref_clk, .sclOe, .sdaOe, .stretch, .sclIn, .sdaIn);
	// ==========
	// clock, timeout, scl-to-sda gap
	initial forever #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		gap <= sclOe ? 0 : gap + (sdaOe ? 1 : 0);
		if (cyc == 30000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// polling is slow on purpose: no fixed latency assumed
	task automatic idle();
		do apb(0, STAT_OFS, 0); while (rd[BUSY_BIT] !== 1'b0);
	endtask
	task automatic print_verdict();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		srst <= 0;
		for (int i = 0; i < 5; i++) begin
			apb(0, 8'(4 * i), 0);
			chk("reset", i == 2 ? 32'(BRG_RESET) : 0, rd);
			chk("err", 32'(i == 4), 32'(err));
		end
		for (int k = 0; k < 4; k++) begin
			v = k & 1;
			rel = ($random(seed) & 3) + 2;
			stretch <= 4'($random(seed) & 3);
			expBuf = $random(seed) & 8'hff;
			apb(1, BRG_OFS, rel);
			apb(1, BUF_OFS, expBuf);
			bufModel.push_back(expBuf);
			apb(1, CTRL_OFS, v << ACK_VALUE_BIT | 1 << HOLD_SCL_BIT | 1 << ACK_START_BIT);
			apb(1, BUF_OFS, ~expBuf);
			idle();
			chk("ackstat", 1 << WRITE_COLLISION_FLAG_BIT, rd);
			chk("ackhold", 1, sclOe);
			chk("pinlow", 0, {sclOut, sdaOut});
			apb(0, CTRL_OFS, 0);
			chk("ackctrl", v << ACK_VALUE_BIT | 1 << HOLD_SCL_BIT, rd);
			apb(1, STAT_OFS, 1 << WRITE_COLLISION_FLAG_BIT);
			apb(1, CTRL_OFS, 1 << STOP_START_BIT);
			apb(1, BUF_OFS, 0);
			idle();
			chk("stopstat", 7, rd);
			chk("gap", rel + 1, gap);
			chk("irq", 1, portIrqFlag);
			apb(1, STAT_OFS, 7);
			apb(0, BUF_OFS, 0);
			chk("buf", bufModel.pop_front(), rd);
			chk("irqclr", 0, portIrqFlag);
		end
		print_verdict();
	end
endmodule
bind ams_seq ams_seq_monitor ams_seq_monitor_i (.*);
